//--- testbench/tb.sv
// Self-checking bench of the OUT endpoint size and PHY gate block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import uoep_pkg::*;
    logic              clk, rst, awv, wv, bre, arv, rre, en, iso, susp;
    logic              awr, wrr, bv, arr, rv, halt, done, irq, pw, pd;
    logic [3:0]        awa, ara;
    logic [1:0]        br, rr, pp;
    logic [31:0]       wd, rdd, seed;
    logic [BYTE_W-1:0] pb;
    int                n_errors, cmp_count, pkt, byt, pid;
    int                n_done = 0;
    uoep_top i_uoep_top (.i_mclk(clk), .i_srst(rst), .i_s_axi_awaddr(awa),
        .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd),
        .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrr),
        .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bre),
        .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
        .o_s_axi_rdata(rdd), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv),
        .i_s_axi_rready(rre), .i_ep_enabled(en), .i_ep_isochronous(iso),
        .i_fifo_pkt_wr(pw), .i_fifo_pkt_pid(pp), .i_mem_pkt_rd(pd),
        .i_mem_pkt_bytes(pb), .i_phy_suspended(susp), .o_phy_clock_halt(halt),
        .o_xfer_complete(done), .o_irq(irq));
    uoep_host i_uoep_host (.i_mclk(clk), .o_pkt(pw), .o_pid(pp), .o_drain(pd), .o_bytes(pb));
    // Clock of 40 ns period.
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Counts completion pulses.
    always @(posedge clk)
        if (done === 1'b1) n_done <= n_done + 1;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Expected transfer size word from the reference counters.
    function automatic logic [31:0] xsz();
        return {1'b0, pid[1:0], pkt[9:0], byt[18:0]};
    endfunction : xsz
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask : chk
    task automatic end_sim();
        if (n_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    // Bus write; each channel is released when it is taken.
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrr) wv <= 1'b0;
        end while (bv !== 1'b1);
        bre <= 1'b0;
        chk({30'h0, br}, {30'h0, er});
    endtask : wr
    // Bus read with expected data and response.
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rre <= 1'b0;
        chk(rdd, e);
        chk({30'h0, rr}, {30'h0, er});
    endtask : rd
    // Cuts a hung run short.
    initial
    begin
        #2000000;
        n_errors++;
        end_sim();
    end
    // Main sequence.
    initial
    begin
        {awv, wv, bre, arv, rre, en, iso, susp, awa, ara, wd} = '0;
        seed = 32'h1016;
        rst = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a += 4) rd(a[3:0], 32'h0, RESP_OKAY);
        wr(OFS_PHY_GATE, 32'hffffffef, RESP_OKAY);
        rd(OFS_PHY_GATE, 32'h1, RESP_OKAY);
        chk({31'h0, halt}, 32'h1);
        wr(OFS_PHY_GATE, 32'h0, RESP_OKAY);
        rd(OFS_PHY_GATE, 32'h0, RESP_OKAY);
        chk({31'h0, halt}, 32'h0);
        wr(4'h6, 32'h1, RESP_SLVERR);
        rd(4'h6, 32'h0, RESP_SLVERR);
        rd(OFS_PHY_GATE, 32'h0, RESP_OKAY);
        pkt = int'((rnd() & 32'h3f8) | 32'h8);
        byt = 256;
        pid = 3;
        wr(OFS_XFER_SIZE, xsz() | 32'h8000_0000, RESP_OKAY);
        rd(OFS_XFER_SIZE, xsz(), RESP_OKAY);
        wr(OFS_INT_MASK, 32'h3, RESP_OKAY);
        i_uoep_host.pkt(2'h0);
        rd(OFS_XFER_SIZE, xsz(), RESP_OKAY);
        @(posedge clk);
        en <= 1'b1;
        iso <= 1'b1;
        wr(OFS_XFER_SIZE, 32'h0, RESP_OKAY);
        rd(OFS_XFER_SIZE, xsz(), RESP_OKAY);
        for (int p = 0; p < 4; p++)
        begin
            i_uoep_host.pkt(p[1:0]);
            pid = p;
            pkt--;
            rd(OFS_XFER_SIZE, xsz(), RESP_OKAY);
            i_uoep_host.drain(19'h40);
            byt -= 64;
            rd(OFS_XFER_SIZE, xsz(), RESP_OKAY);
        end
        chk(n_done, 32'h1);
        rd(OFS_INT_STS, 32'h1, RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_INT_STS, 32'h1, RESP_OKAY);
        rd(OFS_INT_STS, 32'h0, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        // One packet size per load; a bulk endpoint keeps the stored PID.
        @(posedge clk);
        en <= 1'b0;
        iso <= 1'b0;
        pid = 1;
        byt = 64;
        wr(OFS_XFER_SIZE, xsz(), RESP_OKAY);
        @(posedge clk);
        en <= 1'b1;
        i_uoep_host.pkt(2'h2);
        pkt--;
        i_uoep_host.drain(19'h50);
        byt = 0;
        rd(OFS_XFER_SIZE, xsz(), RESP_OKAY);
        chk(n_done, 32'h2);
        wr(OFS_INT_STS, 32'h1, RESP_OKAY);
        @(posedge clk);
        en <= 1'b0;
        susp <= 1'b1;
        repeat (4) @(posedge clk);
        rd(OFS_PHY_GATE, 32'h10, RESP_OKAY);
        rd(OFS_INT_STS, 32'h2, RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        susp <= 1'b0;
        wr(OFS_INT_STS, 32'h2, RESP_OKAY);
        rd(OFS_PHY_GATE, 32'h0, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        // A reset in mid-run clears what the run has set.
        wr(OFS_PHY_GATE, 32'h1, RESP_OKAY);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk({31'h0, halt}, 32'h0);
        rd(OFS_XFER_SIZE, 32'h0, RESP_OKAY);
        rd(OFS_INT_MASK, 32'h0, RESP_OKAY);
        end_sim();
    end
endmodule : tb
`default_nettype wire

//--- testbench/uoep_host.sv
// Host side model that delivers packets and drains them to memory.
`timescale 1ns/1ps
`default_nettype none
module uoep_host
    import uoep_pkg::*;
(
    input  wire logic                        i_mclk,  // System clock.
    output var  logic                        o_pkt,   // Packet into FIFO.
    output var  logic [1:0]                  o_pid,   // Its data PID.
    output var  logic                        o_drain, // Packet to memory.
    output var  logic [uoep_pkg::BYTE_W-1:0] o_bytes  // Drained byte count.
);
    // Idle levels at time zero.
    initial
    begin
        o_pkt   = 1'b0;
        o_pid   = 2'h0;
        o_drain = 1'b0;
        o_bytes = '0;
    end
    // One packet with PID p; the PID is inverted once it is no longer valid.
    task automatic pkt(input logic [1:0] p);
        @(posedge i_mclk);
        o_pkt <= 1'b1;
        o_pid <= p;
        @(posedge i_mclk);
        o_pkt <= 1'b0;
        o_pid <= ~p;
    endtask : pkt
    // One packet of n bytes leaves the FIFO; the count is inverted afterwards.
    task automatic drain(input logic [BYTE_W-1:0] n);
        @(posedge i_mclk);
        o_drain <= 1'b1;
        o_bytes <= n;
        @(posedge i_mclk);
        o_drain <= 1'b0;
        o_bytes <= ~n;
    endtask : drain
endmodule : uoep_host
`default_nettype wire

//--- verilog/uoep_axil.sv
// AXI4-Lite slave that turns bus transfers into register strobes.
`timescale 1ns/1ps
`default_nettype none
module uoep_axil
    import uoep_pkg::*;
(
    input  wire logic        i_mclk,    // System clock.
    input  wire logic        i_srst,    // Synchronous reset.
    input  wire logic [3:0]  i_awaddr,  // Write address.
    input  wire logic        i_awvalid, // Write address valid.
    output var  logic        o_awready, // Write address ready.
    input  wire logic [31:0] i_wdata,   // Write data.
    input  wire logic [3:0]  i_wstrb,   // Write strobes.
    input  wire logic        i_wvalid,  // Write data valid.
    output var  logic        o_wready,  // Write data ready.
    output var  logic [1:0]  o_bresp,   // Write response.
    output var  logic        o_bvalid,  // Write response valid.
    input  wire logic        i_bready,  // Write response ready.
    input  wire logic [3:0]  i_araddr,  // Read address.
    input  wire logic        i_arvalid, // Read address valid.
    output var  logic        o_arready, // Read address ready.
    output var  logic [31:0] o_rdata,   // Read data.
    output var  logic [1:0]  o_rresp,   // Read response.
    output var  logic        o_rvalid,  // Read data valid.
    input  wire logic        i_rready,  // Read data ready.
    uoep_reg_if.bus          ifc        // Register strobes.
);
    uoep_axil_s r_reg;
    uoep_axil_s r_next;

    // Address and data are taken in either order; one write at a time.
    always_comb
    begin
        r_next = r_reg;
        r_next.wr_en = 1'b0;
        if (i_awvalid && r_reg.awready)
        begin
            r_next.aw_have = 1'b1;
            r_next.addr    = i_awaddr;
        end
        if (i_wvalid && r_reg.wready)
        begin
            r_next.w_have = 1'b1;
            r_next.data   = i_wdata;
            r_next.strb   = i_wstrb;
        end
        case (r_reg.wst)
            UOEP_WST_COLLECT:
                if (r_reg.aw_have && r_reg.w_have)
                begin
                    r_next.wr_en  = uoep_mapped(r_reg.addr);
                    r_next.bvalid = 1'b1;
                    r_next.bresp  = uoep_mapped(r_reg.addr) ? RESP_OKAY : RESP_SLVERR;
                    r_next.wst    = UOEP_WST_RESP;
                end
            UOEP_WST_RESP:
                if (i_bready)
                begin
                    r_next.bvalid  = 1'b0;
                    r_next.aw_have = 1'b0;
                    r_next.w_have  = 1'b0;
                    r_next.wst     = UOEP_WST_COLLECT;
                end
            default: r_next.wst = UOEP_WST_COLLECT;
        endcase
        r_next.awready = !r_next.aw_have;
        r_next.wready  = !r_next.w_have;
        if (r_reg.rvalid)
        begin
            if (i_rready)
            begin
                r_next.rvalid  = 1'b0;
                r_next.arready = 1'b1;
            end
        end
        else if (i_arvalid && r_reg.arready)
        begin
            r_next.rvalid  = 1'b1;
            r_next.arready = 1'b0;
            r_next.rdata   = uoep_mapped(i_araddr) ? ifc.rd_data : 32'h0000_0000;
            r_next.rresp   = uoep_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // State register.
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            r_reg <= '{wst: UOEP_WST_COLLECT, awready: 1'b1, wready: 1'b1,
                       arready: 1'b1, default: '0};
        else
            r_reg <= r_next;
    end

    // Outputs and strobes.
    assign o_awready   = r_reg.awready;
    assign o_wready    = r_reg.wready;
    assign o_bvalid    = r_reg.bvalid;
    assign o_bresp     = r_reg.bresp;
    assign o_arready   = r_reg.arready;
    assign o_rvalid    = r_reg.rvalid;
    assign o_rdata     = r_reg.rdata;
    assign o_rresp     = r_reg.rresp;
    assign ifc.wr_en   = r_reg.wr_en;
    assign ifc.wr_addr = r_reg.addr;
    assign ifc.wr_data = r_reg.data;
    assign ifc.wr_strb = r_reg.strb;
    assign ifc.rd_addr = i_araddr;
endmodule : uoep_axil
`default_nettype wire

//--- verilog/uoep_countdown.sv
// Packet and byte countdowns of one OUT endpoint.
`timescale 1ns/1ps
`default_nettype none
module uoep_countdown
    import uoep_pkg::*;
(
    input  wire logic              i_mclk,      // System clock.
    input  wire logic              i_srst,      // Synchronous reset.
    input  wire logic              i_load,      // Software load pulse.
    input  wire logic [PKT_W-1:0]  i_load_pkt,  // Packet count to load.
    input  wire logic [BYTE_W-1:0] i_load_byte, // Byte count to load.
    input  wire logic              i_owned,     // Endpoint enabled.
    input  wire logic              i_pkt_wr,    // Packet into FIFO.
    input  wire logic              i_mem_rd,    // Packet to memory.
    input  wire logic [BYTE_W-1:0] i_mem_bytes, // Bytes of that packet.
    output var  logic [PKT_W-1:0]  o_pkt,       // Packet countdown.
    output var  logic [BYTE_W-1:0] o_bytes,     // Byte countdown.
    output var  logic              o_done       // Byte count hit zero.
);
    uoep_cnt_s r_reg;
    uoep_cnt_s r_next;

    // Apart from a software load, counts move only while the endpoint is owned by hardware.
    always_comb
    begin
        r_next = r_reg;
        r_next.done = 1'b0;
        if (i_load)
        begin
            r_next.pkt   = i_load_pkt;
            r_next.bytes = i_load_byte;
        end
        else if (i_owned)
        begin
            if (i_pkt_wr && r_reg.pkt != PKT_RST)
                r_next.pkt = r_reg.pkt - 1'b1;
            if (i_mem_rd && r_reg.bytes != BYTE_RST)
            begin
                r_next.bytes = (i_mem_bytes >= r_reg.bytes) ? BYTE_RST
                                                            : r_reg.bytes - i_mem_bytes;
                r_next.done  = i_mem_bytes >= r_reg.bytes;
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            r_reg <= '{pkt: PKT_RST, bytes: BYTE_RST, done: 1'b0};
        else
            r_reg <= r_next;
    end

    assign o_pkt   = r_reg.pkt;
    assign o_bytes = r_reg.bytes;
    assign o_done  = r_reg.done;
endmodule : uoep_countdown
`default_nettype wire

//--- verilog/uoep_pkg.sv
// Constants and types for the OUT endpoint size and PHY gate block.
package uoep_pkg;
    // Register byte offsets on the slave port.
    localparam logic [3:0] OFS_XFER_SIZE = 4'h0;
    localparam logic [3:0] OFS_PHY_GATE  = 4'h4;
    localparam logic [3:0] OFS_INT_STS   = 4'h8;
    localparam logic [3:0] OFS_INT_MASK  = 4'hc;
    // Field positions and widths.
    localparam int PID_LSB  = 29;
    localparam int PKT_LSB  = 19;
    localparam int SUSP_BIT = 4;
    localparam int HALT_BIT = 0;
    localparam int PKT_W    = 10;
    localparam int BYTE_W   = 19;
    localparam int INT_W    = 2;
    localparam int INT_DONE = 0;
    localparam int INT_SUSP = 1;
    // Values after reset.
    localparam logic [PKT_W-1:0]  PKT_RST  = 10'h000;
    localparam logic [BYTE_W-1:0] BYTE_RST = 19'h00000;
    localparam logic [1:0]        PID_RST  = 2'h0;
    localparam logic              HALT_RST = 1'b0;
    localparam logic [INT_W-1:0]  INT_RST  = 2'h0;
    // Data PID codes as reported; 2'h1 to 2'h3 also count SETUP packets.
    localparam logic [1:0] PID_DATA0 = 2'h0;
    localparam logic [1:0] PID_DATA2 = 2'h1;
    localparam logic [1:0] PID_DATA1 = 2'h2;
    localparam logic [1:0] PID_MDATA = 2'h3;
    // Bus responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        UOEP_WST_COLLECT = 2'b01,
        UOEP_WST_RESP    = 2'b10
    } uoep_wst_e;

    typedef struct packed {
        uoep_wst_e   wst;
        logic        aw_have;
        logic        w_have;
        logic [3:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        wr_en;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } uoep_axil_s;

    typedef struct packed {
        logic [PKT_W-1:0]  pkt;
        logic [BYTE_W-1:0] bytes;
        logic              done;
    } uoep_cnt_s;

    // Only aligned words are mapped.
    function automatic logic uoep_mapped(input logic [3:0] a);
        return a[1:0] == 2'h0;
    endfunction : uoep_mapped

    // Merges write data into an old word under byte strobes.
    function automatic logic [31:0] uoep_merge(input logic [31:0] old,
                                               input logic [31:0] dat,
                                               input logic [3:0]  strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (dat & m);
    endfunction : uoep_merge
endpackage : uoep_pkg

//--- verilog/uoep_reg_if.sv
// Register access carrier between the bus slave and the core.
`timescale 1ns/1ps
`default_nettype none
interface uoep_reg_if;
    logic        wr_en;
    logic [3:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [3:0]  rd_addr;
    logic [31:0] rd_data;
    modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input rd_data);
    modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output rd_data);
endinterface : uoep_reg_if
`default_nettype wire

//--- verilog/uoep_top.sv
// Top of the OUT endpoint size bookkeeping and PHY clock gate block.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module uoep_top
    import uoep_pkg::*;
(
    input  wire logic              i_mclk,           // System clock, 25 MHz.
    input  wire logic              i_srst,           // Synchronous reset.
    input  wire logic [3:0]        i_s_axi_awaddr,   // Write address.
    input  wire logic              i_s_axi_awvalid,  // Write address valid.
    output var  logic              o_s_axi_awready,  // Write address ready.
    input  wire logic [31:0]       i_s_axi_wdata,    // Write data.
    input  wire logic [3:0]        i_s_axi_wstrb,    // Write strobes.
    input  wire logic              i_s_axi_wvalid,   // Write data valid.
    output var  logic              o_s_axi_wready,   // Write data ready.
    output var  logic [1:0]        o_s_axi_bresp,    // Write response.
    output var  logic              o_s_axi_bvalid,   // Write response valid.
    input  wire logic              i_s_axi_bready,   // Write response ready.
    input  wire logic [3:0]        i_s_axi_araddr,   // Read address.
    input  wire logic              i_s_axi_arvalid,  // Read address valid.
    output var  logic              o_s_axi_arready,  // Read address ready.
    output var  logic [31:0]       o_s_axi_rdata,    // Read data.
    output var  logic [1:0]        o_s_axi_rresp,    // Read response.
    output var  logic              o_s_axi_rvalid,   // Read data valid.
    input  wire logic              i_s_axi_rready,   // Read data ready.
    input  wire logic              i_ep_enabled,     // Endpoint enable bit.
    input  wire logic              i_ep_isochronous, // Endpoint is isochronous.
    input  wire logic              i_fifo_pkt_wr,    // Packet written to FIFO.
    input  wire logic [1:0]        i_fifo_pkt_pid,   // Data PID of that packet.
    input  wire logic              i_mem_pkt_rd,     // Packet drained to memory.
    input  wire logic [BYTE_W-1:0] i_mem_pkt_bytes,  // Bytes in that packet.
    input  wire logic              i_phy_suspended,  // PHY suspend level, async.
    output var  logic              o_phy_clock_halt, // Stops the PHY clock.
    output var  logic              o_xfer_complete,  // Byte count reached zero.
    output var  logic              o_irq             // Level interrupt.
);
    // Core state held in one record.
    typedef struct packed {
        logic [1:0]       pid;
        logic             halt;
        logic [1:0]       sync;
        logic             susp_d;
        logic [INT_W-1:0] sts;
        logic [INT_W-1:0] mask;
        logic             irq;
    } uoep_top_s;

    uoep_top_s r_reg;
    uoep_top_s r_next;

    uoep_reg_if ifc ();

    logic [PKT_W-1:0]  cnt_pkt;
    logic [BYTE_W-1:0] cnt_bytes;
    logic              cnt_done;
    logic              xfer_wr;
    logic [31:0]       xfer_word;
    logic [31:0]       xfer_new;
    logic [31:0]       gate_word;
    logic              susp_now;

    // Bus slave.
    uoep_axil u_axil (
        .i_mclk    (i_mclk),
        .i_srst    (i_srst),
        .i_awaddr  (i_s_axi_awaddr),
        .i_awvalid (i_s_axi_awvalid),
        .o_awready (o_s_axi_awready),
        .i_wdata   (i_s_axi_wdata),
        .i_wstrb   (i_s_axi_wstrb),
        .i_wvalid  (i_s_axi_wvalid),
        .o_wready  (o_s_axi_wready),
        .o_bresp   (o_s_axi_bresp),
        .o_bvalid  (o_s_axi_bvalid),
        .i_bready  (i_s_axi_bready),
        .i_araddr  (i_s_axi_araddr),
        .i_arvalid (i_s_axi_arvalid),
        .o_arready (o_s_axi_arready),
        .o_rdata   (o_s_axi_rdata),
        .o_rresp   (o_s_axi_rresp),
        .o_rvalid  (o_s_axi_rvalid),
        .i_rready  (i_s_axi_rready),
        .ifc       (ifc.bus)
    );

    // Current transfer size word; bit 31 is reserved.
    assign xfer_word = {1'b0, r_reg.pid, cnt_pkt, cnt_bytes};
    assign xfer_new  = uoep_merge(xfer_word, ifc.wr_data, ifc.wr_strb);

    // Transfer size writes are dropped while the endpoint is enabled.
    assign xfer_wr = ifc.wr_en && ifc.wr_addr == OFS_XFER_SIZE && !i_ep_enabled;

    // Suspend level after the two synchroniser stages.
    // Suspend status flag.
    assign susp_now = r_reg.sync[1];

    // Gating word with reserved bits at zero.
    assign gate_word = {27'h0000000, susp_now, 3'h0, r_reg.halt};

    // Countdown unit; a software load happens only while disabled.
    uoep_countdown u_cnt (
        .i_mclk      (i_mclk),
        .i_srst      (i_srst),
        .i_load      (xfer_wr),
        .i_load_pkt  (xfer_new[PKT_LSB +: PKT_W]),
        .i_load_byte (xfer_new[BYTE_W-1:0]),
        .i_owned     (i_ep_enabled),
        .i_pkt_wr    (i_fifo_pkt_wr),
        .i_mem_rd    (i_mem_pkt_rd),
        .i_mem_bytes (i_mem_pkt_bytes),
        .o_pkt       (cnt_pkt),
        .o_bytes     (cnt_bytes),
        .o_done      (cnt_done)
    );

    // Register read decode.
    always_comb
    begin
        case (ifc.rd_addr)
            OFS_XFER_SIZE: ifc.rd_data = xfer_word;
            OFS_PHY_GATE:  ifc.rd_data = gate_word;
            OFS_INT_STS:   ifc.rd_data = {30'h00000000, r_reg.sts};
            OFS_INT_MASK:  ifc.rd_data = {30'h00000000, r_reg.mask};
            default:       ifc.rd_data = 32'h0000_0000;
        endcase
    end

    // Next state of the core registers.
    always_comb
    begin
        r_next = r_reg;
        // The first stage feeds only the second.
        r_next.sync   = {r_reg.sync[0], i_phy_suspended};
        r_next.susp_d = r_reg.sync[1];
        if (xfer_wr)
            r_next.pid = xfer_new[PID_LSB +: 2];
        else if (i_ep_enabled && i_ep_isochronous && i_fifo_pkt_wr)
            r_next.pid = i_fifo_pkt_pid;
        if (ifc.wr_en && ifc.wr_addr == OFS_PHY_GATE && ifc.wr_strb[0])
            r_next.halt = ifc.wr_data[HALT_BIT];
        if (ifc.wr_en && ifc.wr_addr == OFS_INT_MASK && ifc.wr_strb[0])
            r_next.mask = ifc.wr_data[INT_W-1:0];
        // Write one to clear; a new event wins over the clear.
        if (ifc.wr_en && ifc.wr_addr == OFS_INT_STS && ifc.wr_strb[0])
            r_next.sts = r_reg.sts & ~ifc.wr_data[INT_W-1:0];
        if (cnt_done)
            r_next.sts[INT_DONE] = 1'b1;
        if (r_reg.sync[1] && !r_reg.susp_d)
            r_next.sts[INT_SUSP] = 1'b1;
        r_next.irq = |(r_next.sts & r_next.mask);
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            r_reg <= '{pid: PID_RST, halt: HALT_RST, sync: 2'h0, susp_d: 1'b0,
                       sts: INT_RST, mask: INT_RST, irq: 1'b0};
        else
            r_reg <= r_next;
    end

    // Halt bit drives the PHY clock stop.
    assign o_phy_clock_halt = r_reg.halt;
    assign o_irq            = r_reg.irq;
    assign o_xfer_complete  = cnt_done;

    // Checks run on the system clock and pause during reset.
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);

    // A drain that empties the byte count.
    sequence s_drain_to_zero;
        i_ep_enabled && i_mem_pkt_rd && cnt_bytes != BYTE_RST
            && i_mem_pkt_bytes >= cnt_bytes;
    endsequence

    // Pulse, zero count, then the sticky bit.
    sequence s_done_report;
        ##1 (o_xfer_complete && cnt_bytes == BYTE_RST) ##1 r_reg.sts[INT_DONE];
    endsequence

    property p_done_irq;
        s_drain_to_zero |-> s_done_report;
    endproperty
    a_done_irq: assert property (p_done_irq)
        else $error("Completion not reported after byte count hit zero.");

    // A masked-in completion must raise the line on the next edge.
    property p_irq_level;
        o_xfer_complete && r_reg.mask[INT_DONE]
            && !(ifc.wr_en && ifc.wr_addr == OFS_INT_MASK) |=> o_irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("Interrupt does not match masked status.");

    property p_pkt_dec;
        i_ep_enabled && i_fifo_pkt_wr && cnt_pkt != PKT_RST
            |=> cnt_pkt == $past(cnt_pkt) - 10'h001;
    endproperty
    a_pkt_dec: assert property (p_pkt_dec)
        else $error("Packet countdown did not drop by one.");

    property p_byte_dec;
        i_ep_enabled && i_mem_pkt_rd && i_mem_pkt_bytes < cnt_bytes
            |=> cnt_bytes == $past(cnt_bytes) - $past(i_mem_pkt_bytes);
    endproperty
    a_byte_dec: assert property (p_byte_dec)
        else $error("Byte countdown did not drop by packet size.");

    property p_owned;
        i_ep_enabled && !i_fifo_pkt_wr && !i_mem_pkt_rd
            |=> $stable(cnt_pkt) && $stable(cnt_bytes);
    endproperty
    a_owned: assert property (p_owned)
        else $error("Owned transfer size changed without an event.");

    property p_pid_capture;
        i_ep_enabled && i_ep_isochronous && i_fifo_pkt_wr
            |=> r_reg.pid == $past(i_fifo_pkt_pid);
    endproperty
    a_pid_capture: assert property (p_pid_capture)
        else $error("Received PID not captured.");

    property p_setup_load;
        ifc.wr_en && ifc.wr_addr == OFS_XFER_SIZE && !i_ep_enabled
            && ifc.wr_strb[3]
            |=> r_reg.pid == $past(ifc.wr_data[PID_LSB +: 2]);
    endproperty
    a_setup_load: assert property (p_setup_load)
        else $error("SETUP count not loaded.");

    property p_susp_flag;
        ##2 (gate_word[SUSP_BIT] == $past(i_phy_suspended, 2));
    endproperty
    a_susp_flag: assert property (p_susp_flag)
        else $error("Suspend flag does not follow the PHY.");

    // Checked on the read path so the decode is covered too.
    property p_reserved;
        (ifc.rd_addr == OFS_XFER_SIZE |-> ifc.rd_data[31] == 1'b0)
            and (ifc.rd_addr == OFS_PHY_GATE |-> ifc.rd_data[31:5] == 27'h0000000
                 && ifc.rd_data[3:1] == 3'h0);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("Reserved bit reads as one.");

    property p_halt_write;
        ifc.wr_en && ifc.wr_addr == OFS_PHY_GATE && ifc.wr_strb[0]
            |=> o_phy_clock_halt == $past(ifc.wr_data[HALT_BIT]) ##1
                $stable(o_phy_clock_halt) || ifc.wr_en;
    endproperty
    a_halt_write: assert property (p_halt_write)
        else $error("PHY clock halt did not follow the write.");

    // Writing a one clears the completion bit unless a new event lands.
    property p_sts_clear;
        ifc.wr_en && ifc.wr_addr == OFS_INT_STS && ifc.wr_strb[0]
            && ifc.wr_data[INT_DONE] && !o_xfer_complete
            |=> !r_reg.sts[INT_DONE];
    endproperty
    a_sts_clear: assert property (p_sts_clear)
        else $error("Completion status not cleared by a written one.");
endmodule : uoep_top
`default_nettype wire
